// *** rtl/dipc_defines.svh ***
// Constants for the digital input channel: register offsets, fields, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef DIPC_DEFINES_SVH
`define DIPC_DEFINES_SVH

// ===========================================================================
// Register byte offsets
`define DIPC_CTRL_ADDR 8'h00
`define DIPC_FACTOR_ADDR 8'h04
`define DIPC_PRESET_ADDR 8'h08
`define DIPC_COUNT_ADDR 8'h0c
`define DIPC_QTY_ADDR 8'h10
`define DIPC_RMEAN_ADDR 8'h14
`define DIPC_RMAX_ADDR 8'h18
`define DIPC_RMIN_ADDR 8'h1c
`define DIPC_DELAY_ADDR 8'h20
`define DIPC_ALARMS_ADDR 8'h24
`define DIPC_ONTOT_ADDR 8'h28
`define DIPC_ONIVL_ADDR 8'h2c
`define DIPC_STATUS_ADDR 8'h30
`define DIPC_SMPDIV_ADDR 8'h34
`define DIPC_ONSCALE_ADDR 8'h38
`define DIPC_EVENT_ADDR 8'h3c

// ===========================================================================
// Control register fields
`define DIPC_CTRL_MODE_LSB 0
`define DIPC_CTRL_UNITMODE 2
`define DIPC_CTRL_MIDNIGHT 3
`define DIPC_CTRL_LOGEACH 4
`define DIPC_CTRL_ACTHIGH 5
`define DIPC_CTRL_DIRECTOUT 6
`define DIPC_CTRL_STATEREC 7
`define DIPC_CTRL_DAYCLR 8

// ===========================================================================
// Reset values and widths
`define DIPC_CTRL_RST 32'h0000_0020
`define DIPC_FACTOR_RST 32'h0000_0001
`define DIPC_SMPDIV_RST 32'h0000_0001
`define DIPC_ONSCALE_RST 32'h0000_0001
`define DIPC_RMIN_RST 32'hffff_ffff
`define DIPC_EVQ_DEPTH 8
`define DIPC_EVQ_AW 3
`define DIPC_EVQ_AW_W 4
`define DIPC_HOURS_PER_IVL_MULT 32'h0000_0001

`endif

// *** rtl/dipc_pkg.sv ***
// Types shared by the digital input channel modules.
// Assumes dipc_defines.svh is on the include path.
`include "dipc_defines.svh"

package dipc_pkg;

  // =========================================================================
  // Channel operating modes.
  typedef enum logic [1:0] {
    DIPC_PULSE,
    DIPC_ALARM,
    DIPC_STATE
  } dipc_mode_type;

  // Alarm sequencer states.
  typedef enum logic [1:0] {
    DIPC_NORMAL,
    DIPC_PREALARM,
    DIPC_ALARMED
  } dipc_alarm_type;

  // Event record kinds written into the event queue.
  typedef enum logic [1:0] {
    DIPC_EV_COUNT,
    DIPC_EV_RISE,
    DIPC_EV_FALL,
    DIPC_EV_ALARM
  } dipc_event_type;

endpackage : dipc_pkg

// *** rtl/dipc_evq_if.sv ***
// Interface carrying event records from the channel core to its queue.
// Assumes one clock domain shared by both modports.
`timescale 1ns/1ns

interface dipc_evq_if;
  logic wrValid;
  logic [31:0] wrData;
  logic rdPop;
  logic [31:0] rdData;
  logic rdValid;
  modport core (output wrValid, output wrData, output rdPop,
                input rdData, input rdValid);
  modport queue (input wrValid, input wrData, input rdPop,
                 output rdData, output rdValid);
endinterface : dipc_evq_if

// *** rtl/dipc_event_mem.sv ***
// Small event memory: timestamped records, oldest dropped when full.
// Assumes the core pops only while rdValid is high.
`timescale 1ns/1ns
`include "dipc_defines.svh"

module dipc_event_mem (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Core side.
  dipc_evq_if.queue evq
);
  import dipc_pkg::*;

  typedef struct packed {
    logic [`DIPC_EVQ_AW-1:0] wrPtr;
    logic [`DIPC_EVQ_AW-1:0] rdPtr;
    logic [`DIPC_EVQ_AW_W-1:0] fill;
    logic [31:0] rdData;
  } dipc_evq_state_type;

  dipc_evq_state_type st_reg, st_next;
  logic [31:0] mem [`DIPC_EVQ_DEPTH];
  logic full;

  // =========================================================================
  // Storage write; overwrite keeps the newest records when full.
  always_ff @(posedge ref_clk) begin
    if (evq.wrValid) begin
      mem[st_reg.wrPtr] <= evq.wrData;
    end
  end

  // Pointer update; a full queue drops its oldest record.
  always_comb begin
    st_next = st_reg;
    full = (st_reg.fill == `DIPC_EVQ_AW_W'(`DIPC_EVQ_DEPTH));
    if (evq.rdPop && st_reg.fill != '0) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
      st_next.fill = st_reg.fill - 1'b1;
    end
    if (evq.wrValid) begin
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
      if (full && !evq.rdPop) begin
        st_next.rdPtr = st_reg.rdPtr + 1'b1;
      end else begin
        st_next.fill = st_next.fill + 1'b1;
      end
    end
    st_next.rdData = mem[st_next.rdPtr];
    // A record written this cycle is not in the array yet; forward it.
    if (evq.wrValid && st_next.rdPtr == st_reg.wrPtr) begin
      st_next.rdData = evq.wrData;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign evq.rdData = st_reg.rdData;
  assign evq.rdValid = (st_reg.fill != '0);

endmodule : dipc_event_mem

// *** rtl/dipc_in_sync.sv ***
// Input conditioner: two-stage synchroniser, polarity and edge pulses.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ns

module dipc_in_sync (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Pin and polarity.
  input wire logic pinIn,
  input wire logic activeHigh,
  // Conditioned outputs.
  output logic active,
  output logic actRise,
  output logic actFall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic v1;
    logic v2;
    logic v3;
  } dipc_sync_type;

  dipc_sync_type st_reg, st_next;

  // Shift chain; only s2 and s3 feed logic, s1 feeds s2 alone.
  always_comb begin
    st_next.s1 = pinIn;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Marks which stages already hold a real pin sample since reset.
    st_next.v1 = 1'b1;
    st_next.v2 = st_reg.v1;
    st_next.v3 = st_reg.v2;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pull-up sensors pull low, so low-active is just an inverted level.
  assign active = activeHigh ? st_reg.s2 : !st_reg.s2;
  // Reset zeroes disagree with a pin idling high, so no edge until primed.
  assign actRise = st_reg.v3 && (st_reg.s2 != st_reg.s3)
                   && active;
  assign actFall = st_reg.v3 && (st_reg.s2 != st_reg.s3)
                   && !active;

endmodule : dipc_in_sync

// *** rtl/dipc_channel.sv ***
// Digital input channel: pulse counter, alarm trigger and on-time meter.
// Assumes AXI4-Lite master on ref_clk and timebase ticks from the logger.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "dipc_defines.svh"

module dipc_channel (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Sensor pin.
  input wire logic pinIn,
  // Timebase ticks from the logger, one cycle each, on ref_clk.
  input wire logic sampleTick,
  input wire logic logTick,
  input wire logic midnightTick,
  input wire logic dayTimeTick,
  input wire logic secondTick,
  input wire logic hourTick,
  input wire logic [31:0] timeStamp,
  // Actions towards the logger.
  output logic alarmIntervals,
  output logic measureAll,
  output logic startOutput,
  output logic inputState,
  output logic logStrobe,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dipc_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl, factor, preset, count, pubCount, qty, ivlStart;
    logic [31:0] rMean, rMax, rMin, delay, delayCnt, alarms;
    logic [31:0] onTot, onIvl, onSec, smpDiv, smpCnt, onScale, pulseAcc;
    logic [31:0] hoursAcc, ivlHours;
    dipc_alarm_type alm;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awHave, wHave, bValid, rValid, measure, startOut, logPulse;
    logic [31:0] rData;
    logic [1:0] rResp, bResp;
  } dipc_state_type;

  dipc_state_type st_reg, st_next;
  dipc_evq_if evq();
  logic active, actRise, actFall;
  logic [31:0] wrMerged;
  dipc_mode_type mode;
  logic evValid;
  logic [31:0] evData;

  // Apply byte strobes to an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Decide whether an address names a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `DIPC_EVENT_ADDR);
  endfunction : mapped

  // =========================================================================
  // Submodules
  dipc_in_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pinIn(pinIn),
    .activeHigh(st_reg.ctrl[`DIPC_CTRL_ACTHIGH]),
    .active(active),
    .actRise(actRise),
    .actFall(actFall)
  );

  dipc_event_mem u_evq (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .evq(evq)
  );

  assign mode = dipc_mode_type'(st_reg.ctrl[`DIPC_CTRL_MODE_LSB +: 2]);

  // =========================================================================
  // Next-state logic: counting, alarm sequence, on-time and bus.
  always_comb begin
    st_next = st_reg;
    st_next.measure = 1'b0;
    st_next.startOut = 1'b0;
    st_next.logPulse = 1'b0;
    evValid = 1'b0;
    evData = '0;
    wrMerged = merge('0, st_reg.wData, st_reg.wStrb);

    // Pulse counter; edges counted immediately, not at sample ticks.
    if (mode == DIPC_PULSE && actRise) begin
      if (st_reg.ctrl[`DIPC_CTRL_UNITMODE]) begin
        if (st_reg.pulseAcc + 1 >= st_reg.factor) begin
          st_next.pulseAcc = '0;
          st_next.count = st_reg.count + 1;
          evValid = st_reg.ctrl[`DIPC_CTRL_LOGEACH];
        end else begin
          st_next.pulseAcc = st_reg.pulseAcc + 1;
        end
      end else begin
        st_next.count = st_reg.count + st_reg.factor;
        evValid = st_reg.ctrl[`DIPC_CTRL_LOGEACH];
      end
      evData = {DIPC_EV_COUNT, timeStamp[29:0]};
    end
    // Midnight clear keeps the interval baseline consistent.
    if (mode == DIPC_PULSE && midnightTick
        && st_reg.ctrl[`DIPC_CTRL_MIDNIGHT]) begin
      st_next.count = st_next.count - st_reg.count; // Keeps a same-cycle pulse.
      st_next.pubCount = '0;
      st_next.ivlStart = st_reg.ivlStart - st_reg.count;
    end
    // Sample divider gates publication of the running count.
    if (sampleTick) begin
      if (st_reg.smpCnt + 1 >= st_reg.smpDiv) begin
        st_next.smpCnt = '0;
        st_next.pubCount = st_next.count;
      end else begin
        st_next.smpCnt = st_reg.smpCnt + 1;
      end
    end

    // Alarm sequencer.
    case (st_reg.alm)
      DIPC_NORMAL: begin
        if (mode == DIPC_ALARM && active) begin
          st_next.alm = DIPC_PREALARM;
          st_next.delayCnt = '0;
        end
      end
      DIPC_PREALARM: begin
        if (!active || mode != DIPC_ALARM) begin
          st_next.alm = DIPC_NORMAL;
        end else if (st_reg.delayCnt + 1 >= st_reg.delay) begin
          st_next.alm = DIPC_ALARMED;
          st_next.alarms = st_reg.alarms + 1;
          st_next.measure = 1'b1;
          evValid = 1'b1;
          evData = {DIPC_EV_ALARM, timeStamp[29:0]};
        end else begin
          st_next.delayCnt = st_reg.delayCnt + 1;
        end
      end
      DIPC_ALARMED: begin
        if (!active || mode != DIPC_ALARM) begin
          st_next.alm = DIPC_NORMAL;
          evValid = 1'b1;
          evData = {DIPC_EV_FALL, timeStamp[29:0]};
        end
      end
      default: st_next.alm = DIPC_NORMAL;
    endcase
    // Direct output on both edges of the alarm input.
    if (mode == DIPC_ALARM && st_reg.ctrl[`DIPC_CTRL_DIRECTOUT]
        && (actRise || actFall)) begin
      st_next.startOut = 1'b1;
    end

    // State input: log transitions and accumulate on-time.
    if (mode == DIPC_STATE && (actRise || actFall)) begin
      evValid = 1'b1;
      evData = {actRise ? DIPC_EV_RISE : DIPC_EV_FALL, timeStamp[29:0]};
    end
    if (mode == DIPC_STATE && active && secondTick) begin
      st_next.onSec = st_reg.onSec + 1;
      st_next.onIvl = st_reg.onIvl + 1;
    end
    if (mode == DIPC_STATE && active && hourTick) begin
      st_next.hoursAcc = st_reg.hoursAcc + 1;
    end
    if (dayTimeTick && st_reg.ctrl[`DIPC_CTRL_DAYCLR]) begin
      st_next.hoursAcc = '0;
    end

    // Log interval: quantity, rates, on-time snapshots.
    if (logTick) begin
      st_next.logPulse = 1'b1;
      st_next.qty = st_next.count - st_reg.ivlStart;
      st_next.ivlStart = st_next.count;
      st_next.rMean = (st_next.count - st_reg.preset)
                      * `DIPC_HOURS_PER_IVL_MULT;
      if (st_next.qty > st_reg.rMax) begin
        st_next.rMax = st_next.qty;
      end
      if (st_next.qty < st_reg.rMin) begin
        st_next.rMin = st_next.qty;
      end
      st_next.onTot = st_next.hoursAcc;
      st_next.ivlHours = st_reg.onIvl / st_reg.onScale;
      st_next.onIvl = '0;
    end

    // AXI write: address and data captured in either order.
    if (s_axi_awvalid && !st_reg.awHave) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.wHave) begin
      st_next.wHave = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    if (st_reg.awHave && st_reg.wHave && !st_reg.bValid) begin
      st_next.awHave = 1'b0;
      st_next.wHave = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = mapped(st_reg.awAddr) ? 2'b00 : 2'b10;
      wrMerged = merge('0, st_reg.wData, st_reg.wStrb);
      if (st_reg.awAddr == `DIPC_CTRL_ADDR) begin
        st_next.ctrl = merge(st_reg.ctrl, st_reg.wData, st_reg.wStrb);
      end else if (st_reg.awAddr == `DIPC_FACTOR_ADDR) begin
        st_next.factor = merge(st_reg.factor, st_reg.wData, st_reg.wStrb);
      end else if (st_reg.awAddr == `DIPC_PRESET_ADDR) begin
        st_next.preset = wrMerged;
        st_next.count = wrMerged;
        st_next.pubCount = wrMerged;
        st_next.ivlStart = wrMerged;
      end else if (st_reg.awAddr == `DIPC_DELAY_ADDR) begin
        st_next.delay = wrMerged;
      end else if (st_reg.awAddr == `DIPC_ALARMS_ADDR) begin
        st_next.alarms = wrMerged;
      end else if (st_reg.awAddr == `DIPC_ONTOT_ADDR) begin
        st_next.hoursAcc = wrMerged;
        st_next.onTot = wrMerged;
      end else if (st_reg.awAddr == `DIPC_SMPDIV_ADDR) begin
        st_next.smpDiv = wrMerged;
      end else if (st_reg.awAddr == `DIPC_ONSCALE_ADDR) begin
        st_next.onScale = (wrMerged == '0) ? `DIPC_ONSCALE_RST : wrMerged;
      end
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end

    // AXI read: one-cycle registered answer.
    evq.rdPop = 1'b0;
    if (s_axi_arvalid && !st_reg.rValid) begin
      st_next.rValid = 1'b1;
      st_next.rResp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      st_next.rData = '0;
      if (s_axi_araddr == `DIPC_CTRL_ADDR) begin
        st_next.rData = st_reg.ctrl;
      end else if (s_axi_araddr == `DIPC_FACTOR_ADDR) begin
        st_next.rData = st_reg.factor;
      end else if (s_axi_araddr == `DIPC_PRESET_ADDR) begin
        st_next.rData = st_reg.count;
      end else if (s_axi_araddr == `DIPC_COUNT_ADDR) begin
        st_next.rData = st_reg.pubCount;
      end else if (s_axi_araddr == `DIPC_QTY_ADDR) begin
        st_next.rData = st_reg.qty;
      end else if (s_axi_araddr == `DIPC_RMEAN_ADDR) begin
        st_next.rData = st_reg.rMean;
      end else if (s_axi_araddr == `DIPC_RMAX_ADDR) begin
        st_next.rData = st_reg.rMax;
      end else if (s_axi_araddr == `DIPC_RMIN_ADDR) begin
        st_next.rData = st_reg.rMin;
      end else if (s_axi_araddr == `DIPC_DELAY_ADDR) begin
        st_next.rData = st_reg.delay;
      end else if (s_axi_araddr == `DIPC_ALARMS_ADDR) begin
        st_next.rData = st_reg.alarms;
      end else if (s_axi_araddr == `DIPC_ONTOT_ADDR) begin
        st_next.rData = st_reg.onTot;
      end else if (s_axi_araddr == `DIPC_ONIVL_ADDR) begin
        st_next.rData = st_reg.ivlHours;
      end else if (s_axi_araddr == `DIPC_STATUS_ADDR) begin
        st_next.rData = {27'h0, evq.rdValid, st_reg.alm, active, 1'b0};
      end else if (s_axi_araddr == `DIPC_SMPDIV_ADDR) begin
        st_next.rData = st_reg.smpDiv;
      end else if (s_axi_araddr == `DIPC_ONSCALE_ADDR) begin
        st_next.rData = st_reg.onScale;
      end else if (s_axi_araddr == `DIPC_EVENT_ADDR) begin
        st_next.rData = evq.rdData;
        evq.rdPop = evq.rdValid; // Reading the event word consumes it.
      end
    end
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
    end
  end

  assign evq.wrValid = evValid;
  assign evq.wrData = evData;

  // =========================================================================
  // State register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= `DIPC_CTRL_RST;
      st_reg.factor <= `DIPC_FACTOR_RST;
      st_reg.smpDiv <= `DIPC_SMPDIV_RST;
      st_reg.onScale <= `DIPC_ONSCALE_RST;
      st_reg.rMin <= `DIPC_RMIN_RST;
      st_reg.alm <= DIPC_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // =========================================================================
  // Outputs.
  assign alarmIntervals = (st_reg.alm == DIPC_ALARMED);
  assign measureAll = st_reg.measure;
  assign startOutput = st_reg.startOut;
  assign inputState = active;
  assign logStrobe = st_reg.logPulse;
  assign s_axi_awready = !st_reg.awHave;
  assign s_axi_wready = !st_reg.wHave;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_arready = !st_reg.rValid;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;

endmodule : dipc_channel

// *** testbench/dipc_channel_sva.sv ***
// Concurrent checks on the digital input channel top ports.
// Assumes a bind onto dipc_channel, one ref_clk domain.
`timescale 1ns/1ns

// ======================================================================
// Checker
module dipc_channel_sva (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Watched ports.
  input wire logic logTick,
  input wire logic alarmIntervals,
  input wire logic measureAll,
  input wire logic startOutput,
  input wire logic inputState,
  input wire logic logStrobe,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // A single domain, so one clocking and one disable serve every check.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Bus answers must stand until taken; a read answer comes the cycle after its address.
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped before rready");
  AST_RNEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Logger actions.
  AST_MPULSE: assert property (measureAll |=> !measureAll)
    else $error("measure request longer than one cycle");
  AST_MENTRY: assert property ($rose(alarmIntervals) |-> ##[0:2] measureAll)
    else $error("no measurement on alarm entry");
  AST_SPULSE: assert property (startOutput |=> !startOutput)
    else $error("output start longer than one cycle");
  AST_LOGSTB: assert property (logTick |=> logStrobe)
    else $error("log strobe missing after log tick");
  AST_LOGSRC: assert property (logStrobe |-> $past(logTick))
    else $error("log strobe without log tick");
  AST_ALMIN: assert property ($rose(alarmIntervals) |-> $past(inputState))
    else $error("alarm entered with input inactive");
endmodule : dipc_channel_sva

bind dipc_channel dipc_channel_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .logTick(logTick), .alarmIntervals(alarmIntervals),
  .measureAll(measureAll), .startOutput(startOutput),
  .inputState(inputState), .logStrobe(logStrobe),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// *** testbench/dipc_pulse_sensor.sv ***
// Behavioural switch or pulse sensor on the channel pin.
// Assumes the bench picks the pull mode and the contact level.
`timescale 1ns/1ns

// ======================================================================
// Sensor
module dipc_pulse_sensor (
  // Configuration and stimulus.
  pullUp,
  contact,
  // Pin towards the channel.
  pin
);
  input wire logic pullUp;
  input wire logic contact;
  output logic pin;
  // The pull resistor holds the idle level, so an open contact never floats.
  assign pin = pullUp ? !contact : contact;
endmodule : dipc_pulse_sensor

// *** testbench/digital_input_pulse_alarm_ontime_bench.sv ***
// Self-checking bench for the digital input channel.
// Assumes the sensor model drives the pin and AXI4-Lite reaches registers.
`timescale 1ns/1ns
`include "dipc_defines.svh"

// ======================================================================
// Bench top
module digital_input_pulse_alarm_ontime_bench;
  logic clk, rstN, act, pullUp, smp, lg, awv, wv, bRdy, arv, rRdy;
  logic [7:0] awA, arA;
  logic [31:0] wD, ts, got;
  logic [1:0] rsp;
  logic [15:0] rnd;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h1c, 8'h34, 8'h38};
  logic [31:0] rv [5] = '{32'h20, 32'h1, 32'hffffffff, 32'h1, 32'h1};
  wire logic pin, aIvl, meas, sOut, inSt, lStb, awR, wR, bV, arR, rV;
  wire logic [1:0] bR, rR;
  wire logic [31:0] rD;
  int errors, comparisons, cnt, n, f, p;

  dipc_pulse_sensor u_sen (.pullUp(pullUp), .contact(act), .pin(pin));
  dipc_channel u_dut (.ref_clk(clk), .arst_n(rstN), .pinIn(pin),
    .sampleTick(smp), .logTick(lg), .midnightTick(1'h0),
    .dayTimeTick(1'h0), .secondTick(1'h0), .hourTick(1'h0), .timeStamp(ts),
    .alarmIntervals(aIvl), .measureAll(meas), .startOutput(sOut),
    .inputState(inSt), .logStrobe(lStb), .s_axi_awaddr(awA),
    .s_axi_awvalid(awv), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wR),
    .s_axi_bresp(bR), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
    .s_axi_araddr(arA), .s_axi_arvalid(arv), .s_axi_arready(arR),
    .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV),
    .s_axi_rready(rRdy));

  // Free-running 40 ns clock.
  initial begin
    clk = 1'h0;
    forever #20 clk = !clk;
  end

  // Counts output starts so the alarm test can total them.
  always @(posedge clk) if (sOut === 1'h1) cnt++;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Ready is looked at mid-cycle, so it equals what the next edge samples.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic tA, tW, tE;
    if (w) begin
      awA <= a;
      wD <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bRdy <= 1'h1;
    end else begin
      arA <= a;
      arv <= 1'h1;
      rRdy <= 1'h1;
    end
    do begin
      @(negedge clk);
      tA = (awv && awR) || (arv && arR);
      tW = wv && wR;
      tE = w ? bV : rV;
      rsp = w ? bR : rR;
      got = rD;
      @(posedge clk);
      if (tA) begin
        awv <= 1'h0;
        arv <= 1'h0;
      end
      if (tW) wv <= 1'h0;
    end while (!tE);
    bRdy <= 1'h0;
    rRdy <= 1'h0;
    // Let an edge pass so the next call never reassigns these at once.
    @(posedge clk);
  endtask : bus

  task automatic hold(input logic lv, input int c);
    act <= lv;
    repeat (c) @(posedge clk);
  endtask : hold

  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #1200000;
    errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    {act, smp, lg, awv, wv, bRdy, arv, rRdy, rstN} = 9'h000;
    {awA, arA, wD} = 48'h0;
    pullUp = 1'h1;
    rnd = 16'h3bb6;
    ts = 32'h0;
    repeat (6) @(posedge clk);
    rstN <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'h0, ra[i], 32'h0);
      chk("reset value", got, rv[i]);
    end
    bus(1'h0, 8'h40, 32'h0);
    chk("unmapped read", {rsp, got[29:0]}, 32'h80000000);
    bus(1'h1, 8'h02, 32'h5);
    chk("unaligned write", rsp, 2'h2);
    $display("test registers done");
    // Pulse counting with random preset, factor and count.
    rnd = lfsr(rnd);
    ts <= {rnd, rnd};
    p = rnd;
    f = rnd[1:0] + 1;
    n = rnd[4:2] + 1;
    bus(1'h1, `DIPC_CTRL_ADDR, 32'h0);
    bus(1'h1, `DIPC_FACTOR_ADDR, f);
    bus(1'h1, `DIPC_PRESET_ADDR, p);
    repeat (n) begin
      hold(1'h1, 4);
      hold(1'h0, 4);
    end
    bus(1'h0, `DIPC_PRESET_ADDR, 32'h0);
    chk("live count", got, p + n * f);
    bus(1'h0, `DIPC_COUNT_ADDR, 32'h0);
    chk("unpublished", got, p);
    smp <= 1'h1;
    lg <= 1'h1;
    @(posedge clk);
    {smp, lg} <= 2'h0;
    repeat (3) @(posedge clk);
    bus(1'h0, `DIPC_COUNT_ADDR, 32'h0);
    chk("published", got, p + n * f);
    bus(1'h0, `DIPC_QTY_ADDR, 32'h0);
    chk("quantity", got, n * f);
    $display("test pulse done");
    // Alarm: short glitch refused, long hold alarms, two output starts.
    pullUp <= 1'h0;
    bus(1'h1, `DIPC_CTRL_ADDR, 32'h61);
    bus(1'h1, `DIPC_DELAY_ADDR, 32'h14);
    bus(1'h1, `DIPC_ALARMS_ADDR, 32'h0);
    hold(1'h1, 5);
    hold(1'h0, 30);
    chk("prealarm", aIvl, 1'h0);
    cnt = 0;
    hold(1'h1, 20);
    chk("delay", aIvl, 1'h0);
    hold(1'h1, 20);
    chk("alarm", aIvl, 1'h1);
    hold(1'h0, 10);
    chk("starts", cnt, 2);
    bus(1'h0, `DIPC_ALARMS_ADDR, 32'h0);
    chk("alarms", got, 32'h1);
    bus(1'h1, `DIPC_ALARMS_ADDR, 32'h7);
    bus(1'h0, `DIPC_ALARMS_ADDR, 32'h0);
    chk("alarms set", got, 32'h7);
    bus(1'h0, `DIPC_EVENT_ADDR, 32'h0);
    chk("event", got, {2'h3, ts[29:0]});
    $display("test alarm done");
    // State mode: on-time overwrite and input level.
    bus(1'h1, `DIPC_CTRL_ADDR, 32'h22);
    bus(1'h1, `DIPC_ONTOT_ADDR, p);
    bus(1'h0, `DIPC_ONTOT_ADDR, 32'h0);
    chk("ontime", got, p);
    hold(1'h1, 4);
    chk("state high", inSt, 1'h1);
    hold(1'h0, 4);
    chk("state low", inSt, 1'h0);
    $display("test state done");
    complete_run();
  end
endmodule : digital_input_pulse_alarm_ontime_bench
